// [rtl/jtag_prog_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "jtag_prog_cfg.svh"

// Overview of operation
// - instruction register is four bits, sixteen codes possible
// - run-test/idle produces internal execute clocks; also an idle park
// - code C selects one-bit reset register; TAP itself not reset
// - reset bit at one holds chip reset, unlatched, for as long
// - after reset bit clears, chip stays reset for a selectable timeout
// - code 4 loads 16-bit key; update compares and unlocks on match
// - the unlock key is 1010_0011_0111_0000
// - key register clears on power-on reset; programmer clears on exit
// - code 5 selects 15-bit command register
// - capture loads previous result; shift moves it out, command in
// - update presents command; run-test/idle gives one execute clock
// - code 6 selects 8-bit byte register, low bits of command register
// - page-fill update latches byte and writes page buffer within 11 tck
// - page-fill updates alternate low/high, low first after instruction
// - page-fill address increments before each low byte except first
// - code 7 captures flash bytes alternating low/high, low first
// - page-fetch address increments after every high-byte capture
// - chip erase command words then polling the last word
// - flash write entry then address and data byte load prefixes
// - latch, page write and poll words framed by 0110111 words
// - flash read entry then the same address load prefixes
// - read words return low then high data byte in low bits
// - every shift register moves least significant bit first
module jtag_prog_port
	import jtag_prog_pkg::*;
#(
	parameter int unsigned TMO_SHORT_CYC = `TMO_SHORT_US * `CLK_MHZ,
	parameter int unsigned TMO_LONG_CYC = `TMO_LONG_US * `CLK_MHZ
) (
	// system clock and reset
	input wire logic CLK,
	input wire logic RST,
	// test access port
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	output logic TDO,
	output logic TDO_OE_N,
	// chip reset control
	input wire logic RST_TMO_SEL,
	output logic CHIP_RESET,
	output logic PROG_MODE,
	// flash command port
	output logic [14:0] FLASH_CMD,
	output logic FLASH_EXEC,
	input wire logic [14:0] FLASH_RESULT,
	// flash address and page buffer
	output logic [23:0] FLASH_ADDR,
	output logic PBUF_WE,
	output logic [1:0] PBUF_BE,
	output logic [15:0] PBUF_DATA,
	input wire logic [15:0] FLASH_RD_DATA
);

	tck_state_t t_reg;
	tck_state_t t_next;
	sys_state_t s_reg;
	sys_state_t s_next;
	logic exec_pulse;
	logic fill_pulse;
	logic fetch_pulse;

	// ************************************************************
	// test access controller, tck domain
	// ************************************************************

	function automatic tap_state_t tap_step(input tap_state_t s, input logic tms);
		tap_state_t n;
		n = s;
		unique case (s)
			tlr: n = tms ? tlr : idle;
			idle: n = tms ? sel_dr : idle;
			sel_dr: n = tms ? sel_ir : cap_dr;
			cap_dr: n = tms ? ex1_dr : sh_dr;
			sh_dr: n = tms ? ex1_dr : sh_dr;
			ex1_dr: n = tms ? upd_dr : pa_dr;
			pa_dr: n = tms ? ex2_dr : pa_dr;
			ex2_dr: n = tms ? upd_dr : sh_dr;
			upd_dr: n = tms ? sel_dr : idle;
			sel_ir: n = tms ? tlr : cap_ir;
			cap_ir: n = tms ? ex1_ir : sh_ir;
			sh_ir: n = tms ? ex1_ir : sh_ir;
			ex1_ir: n = tms ? upd_ir : pa_ir;
			pa_ir: n = tms ? ex2_ir : pa_ir;
			ex2_ir: n = tms ? upd_ir : sh_ir;
			upd_ir: n = tms ? sel_dr : idle;
		endcase
		return n;
	endfunction : tap_step

	always_comb begin
		t_next = t_reg;
		t_next.rst_meta = RST;
		t_next.rst_sync = t_reg.rst_meta;
		t_next.tap = tap_step(t_reg.tap, TMS);
		unique case (t_reg.tap)
			tlr: begin
				t_next.ir = `IR_BYPASS;
			end
			cap_ir: begin
				t_next.ir_sh = `IR_CAPTURE;
			end
			sh_ir: begin
				t_next.ir_sh = {TDI, t_reg.ir_sh[3:1]};
			end
			upd_ir: begin
				t_next.ir = t_reg.ir_sh;
				if (t_reg.ir_sh == `IR_FILL) begin
					t_next.fill_hi = 1'b0;
					t_next.fill_first = 1'b1;
				end
				if (t_reg.ir_sh == `IR_FETCH) begin
					t_next.fetch_hi = 1'b0;
				end
			end
			cap_dr: begin
				if (t_reg.ir == `IR_CMD && t_reg.prog) begin
					t_next.dr[14:0] = s_reg.res;
				end
				if (t_reg.ir == `IR_FETCH && t_reg.prog) begin
					t_next.dr[7:0] = t_reg.fetch_hi ? s_reg.rd_word[15:8] : s_reg.rd_word[7:0];
					t_next.fetch_hi = !t_reg.fetch_hi;
					if (t_reg.fetch_hi) begin
						t_next.fetch_tgl = !t_reg.fetch_tgl;
					end
				end
			end
			sh_dr: begin
				// lsb leaves first, new bit enters at the top
				unique case (t_reg.ir)
					`IR_RESET: t_next.rst_bit = TDI;
					`IR_UNLOCK: t_next.dr = {TDI, t_reg.dr[15:1]};
					`IR_CMD: t_next.dr[14:0] = {TDI, t_reg.dr[14:1]};
					// byte path on the low command bits
					`IR_FILL, `IR_FETCH: t_next.dr[7:0] = {TDI, t_reg.dr[7:1]};
					default: t_next.bypass = TDI;
				endcase
			end
			upd_dr: begin
				if (t_reg.ir == `IR_UNLOCK) begin
					t_next.key = t_reg.dr;
					t_next.prog = (t_reg.dr == `UNLOCK_KEY);
				end
				// locked port ignores commands and bytes
				if (t_reg.ir == `IR_CMD && t_reg.prog) begin
					t_next.cmd = t_reg.dr[14:0];
					t_next.cmd_pend = 1'b1;
				end
				if (t_reg.ir == `IR_FILL && t_reg.prog) begin
					t_next.fill_byte = t_reg.dr[7:0];
					t_next.fill_bhi = t_reg.fill_hi;
					// pre-increment before low bytes but the first
					t_next.fill_inc = !t_reg.fill_hi && !t_reg.fill_first;
					t_next.fill_hi = !t_reg.fill_hi;
					t_next.fill_first = 1'b0;
					t_next.fill_tgl = !t_reg.fill_tgl;
				end
			end
			idle: begin
				// exactly one execute per presented command
				if (t_reg.cmd_pend) begin
					t_next.cmd_pend = 1'b0;
					t_next.cmd_tgl = !t_reg.cmd_tgl;
				end
			end
			default: begin
			end
		endcase
	end

	// tck may stop between sequences; the chip reset needs no tck edges
	always_ff @(posedge TCK) begin
		if (t_reg.rst_sync) begin
			t_reg <= '0;
			// synchroniser keeps sampling, otherwise the reset could never end
			t_reg.rst_meta <= RST;
			t_reg.rst_sync <= t_reg.rst_meta;
			t_reg.ir <= `IR_BYPASS;
			t_reg.key <= `KEY_RESET;
		end else begin
			t_reg <= t_next;
		end
	end

	always_comb begin
		TDO_OE_N = !(t_reg.tap == sh_dr || t_reg.tap == sh_ir);
		if (t_reg.tap == sh_ir) begin
			TDO = t_reg.ir_sh[0];
		end else begin
			unique case (t_reg.ir)
				`IR_RESET: TDO = t_reg.rst_bit;
				`IR_UNLOCK, `IR_CMD, `IR_FILL, `IR_FETCH: TDO = t_reg.dr[0];
				default: TDO = t_reg.bypass;
			endcase
		end
	end

	// ************************************************************
	// event crossings, tck to system clock
	// ************************************************************

	event_cross exec_cross (
		.clk(CLK),
		.rst(RST),
		.src_toggle(t_reg.cmd_tgl),
		.dst_pulse(exec_pulse)
	);

	event_cross fill_cross (
		.clk(CLK),
		.rst(RST),
		.src_toggle(t_reg.fill_tgl),
		.dst_pulse(fill_pulse)
	);

	event_cross fetch_cross (
		.clk(CLK),
		.rst(RST),
		.src_toggle(t_reg.fetch_tgl),
		.dst_pulse(fetch_pulse)
	);

	// ************************************************************
	// flash control, system clock domain
	// ************************************************************

	// words from tck are set no later than their toggle, so they are
	// stable when the pulse arrives; result and read word settle within
	// a few system cycles, well before the next capture-dr
	always_comb begin
		s_next = s_reg;
		s_next.rbit_meta = t_reg.rst_bit;
		s_next.rbit_sync = s_reg.rbit_meta;
		s_next.prog_meta = t_reg.prog;
		s_next.prog_sync = s_reg.prog_meta;
		s_next.res = FLASH_RESULT;
		s_next.rd_word = FLASH_RD_DATA;
		s_next.exec = 1'b0;
		s_next.pbuf_we = 1'b0;
		if (s_reg.rbit_sync) begin
			s_next.chip_rst = 1'b1;
			s_next.tmo_cnt = RST_TMO_SEL ? 17'(TMO_LONG_CYC) : 17'(TMO_SHORT_CYC);
		end else if (s_reg.tmo_cnt != 17'h00000) begin
			s_next.chip_rst = 1'b1;
			s_next.tmo_cnt = s_reg.tmo_cnt - 17'h00001;
		end else begin
			s_next.chip_rst = 1'b0;
		end
		// command applied for one execute cycle
		// erase words pass to the flash unchanged
		if (exec_pulse) begin
			s_next.cmd = t_reg.cmd;
			s_next.exec = 1'b1;
			// read uses the same address prefixes
			unique case (t_reg.cmd[14:8])
				`PFX_ADDR_EXT: s_next.addr[23:16] = t_reg.cmd[7:0];
				`PFX_ADDR_HIGH: s_next.addr[15:8] = t_reg.cmd[7:0];
				`PFX_ADDR_LOW: s_next.addr[7:0] = t_reg.cmd[7:0];
				`PFX_DATA_LOW: s_next.dlo = t_reg.cmd[7:0];
				`PFX_DATA_HIGH: s_next.dhi = t_reg.cmd[7:0];
				// latch moves the data word to the page buffer
				`PFX_LATCH: begin
					s_next.pbuf_we = 1'b1;
					s_next.pbuf_be = 2'h3;
					s_next.pbuf_data = {s_reg.dhi, s_reg.dlo};
				end
				default: begin
				end
			endcase
		end
		// page buffer write from the fill byte
		if (fill_pulse) begin
			if (t_reg.fill_inc) begin
				s_next.addr = s_reg.addr + 24'h000001;
			end
			s_next.pbuf_we = 1'b1;
			s_next.pbuf_be = t_reg.fill_bhi ? 2'h2 : 2'h1;
			s_next.pbuf_data = {t_reg.fill_byte, t_reg.fill_byte};
		end
		if (fetch_pulse) begin
			s_next.addr = s_reg.addr + 24'h000001;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign CHIP_RESET = s_reg.chip_rst;
	assign PROG_MODE = s_reg.prog_sync;
	assign FLASH_CMD = s_reg.cmd;
	assign FLASH_EXEC = s_reg.exec;
	assign FLASH_ADDR = s_reg.addr;
	assign PBUF_WE = s_reg.pbuf_we;
	assign PBUF_BE = s_reg.pbuf_be;
	assign PBUF_DATA = s_reg.pbuf_data;

	// ************************************************************
	// assertions
	// ************************************************************

	sequence upd_unlock_s;
		t_reg.tap == upd_dr && t_reg.ir == `IR_UNLOCK;
	endsequence

	sequence upd_fill_s;
		t_reg.tap == upd_dr && t_reg.ir == `IR_FILL && t_reg.prog;
	endsequence

	a_reset_follow: assert property (@(posedge CLK) disable iff (RST)
		$rose(s_reg.rbit_sync) |=> CHIP_RESET [*3]) else $error("chip reset not held");

	a_timeout_hold: assert property (@(posedge CLK) disable iff (RST)
		$fell(s_reg.rbit_sync) |=> CHIP_RESET) else $error("reset released without timeout");

	a_key_match: assert property (@(posedge TCK) disable iff (t_reg.rst_sync)
		upd_unlock_s and (t_reg.dr == `UNLOCK_KEY) |=> t_reg.prog) else $error("key not accepted");

	a_key_miss: assert property (@(posedge TCK) disable iff (t_reg.rst_sync)
		upd_unlock_s and (t_reg.dr != `UNLOCK_KEY) |=> !t_reg.prog) else $error("wrong key accepted");

	a_key_cleared: assert property (@(posedge TCK)
		t_reg.rst_sync |=> t_reg.key == `KEY_RESET) else $error("key not cleared by reset");

	a_cmd_locked: assert property (@(posedge TCK) disable iff (t_reg.rst_sync)
		(t_reg.tap == upd_dr && !t_reg.prog && !t_reg.cmd_pend) |=> !t_reg.cmd_pend)
		else $error("command taken while locked");

	a_exec_once: assert property (@(posedge TCK) disable iff (t_reg.rst_sync)
		(t_reg.tap == idle && t_reg.cmd_pend) |=> $changed(t_reg.cmd_tgl) ##1 $stable(t_reg.cmd_tgl))
		else $error("execute clock missing or repeated");

	a_fill_alternate: assert property (@(posedge TCK) disable iff (t_reg.rst_sync)
		upd_fill_s |=> t_reg.fill_hi != $past(t_reg.fill_hi)) else $error("fill byte did not alternate");

	a_fill_first: assert property (@(posedge TCK) disable iff (t_reg.rst_sync)
		upd_fill_s and t_reg.fill_first |=> !t_reg.fill_inc && t_reg.fill_hi)
		else $error("first fill byte advanced address");

	a_fill_write: assert property (@(posedge CLK) disable iff (RST)
		fill_pulse |=> PBUF_WE) else $error("fill byte not written");

	a_fetch_advance: assert property (@(posedge TCK) disable iff (t_reg.rst_sync)
		(t_reg.tap == cap_dr && t_reg.ir == `IR_FETCH && t_reg.prog && t_reg.fetch_hi)
		|=> $changed(t_reg.fetch_tgl) && !t_reg.fetch_hi) else $error("fetch did not advance");

endmodule : jtag_prog_port

`default_nettype wire

// [rtl/jtag_prog_cfg.svh]
`ifndef JTAG_PROG_CFG_SVH
`define JTAG_PROG_CFG_SVH

// ************************************************************
// clock and reset timeout
// ************************************************************
`define CLK_MHZ 25
`define TMO_SHORT_US 65
`define TMO_LONG_US 4100

// ************************************************************
// instruction codes
// ************************************************************
`define IR_WIDTH 4
`define IR_CAPTURE 4'h1
`define IR_RESET 4'hC
`define IR_UNLOCK 4'h4
`define IR_CMD 4'h5
`define IR_FILL 4'h6
`define IR_FETCH 4'h7
`define IR_BYPASS 4'hF

// ************************************************************
// data register layout and unlock key
// ************************************************************
`define KEY_WIDTH 16
`define CMD_WIDTH 15
`define BYTE_WIDTH 8
`define UNLOCK_KEY 16'hA370
`define KEY_RESET 16'h0000

// ************************************************************
// command prefixes, bits 14:8 of a command word
// ************************************************************
`define PFX_ADDR_EXT 7'h0B
`define PFX_ADDR_HIGH 7'h07
`define PFX_ADDR_LOW 7'h03
`define PFX_DATA_LOW 7'h13
`define PFX_DATA_HIGH 7'h17
`define PFX_LATCH 7'h77
`define ADDR_WIDTH 24

`endif

// [rtl/jtag_prog_pkg.sv]
package jtag_prog_pkg;

	typedef enum logic [3:0] {
		tlr, idle, sel_dr, cap_dr, sh_dr, ex1_dr, pa_dr, ex2_dr, upd_dr,
		sel_ir, cap_ir, sh_ir, ex1_ir, pa_ir, ex2_ir, upd_ir
	} tap_state_t;

	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		tap_state_t tap;
		logic [3:0] ir;
		logic [3:0] ir_sh;
		logic [15:0] dr;
		logic rst_bit;
		logic bypass;
		logic [15:0] key;
		logic prog;
		logic [14:0] cmd;
		logic cmd_pend;
		logic cmd_tgl;
		logic fill_hi;
		logic fill_first;
		logic fill_bhi;
		logic fill_inc;
		logic [7:0] fill_byte;
		logic fill_tgl;
		logic fetch_hi;
		logic fetch_tgl;
	} tck_state_t;

	typedef struct packed {
		logic rbit_meta;
		logic rbit_sync;
		logic prog_meta;
		logic prog_sync;
		logic [16:0] tmo_cnt;
		logic chip_rst;
		logic [14:0] cmd;
		logic exec;
		logic [23:0] addr;
		logic [7:0] dlo;
		logic [7:0] dhi;
		logic pbuf_we;
		logic [1:0] pbuf_be;
		logic [15:0] pbuf_data;
		logic [14:0] res;
		logic [15:0] rd_word;
	} sys_state_t;

	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} xfer_state_t;

endpackage : jtag_prog_pkg

// [rtl/event_cross.sv]
`timescale 1ns/1ps
`default_nettype none

module event_cross
	import jtag_prog_pkg::*;
(
	// destination domain
	input wire logic clk,
	input wire logic rst,
	// toggle from the source domain, one flip per event
	input wire logic src_toggle,
	// one-cycle event in the destination domain
	output logic dst_pulse
);

	xfer_state_t state_reg;
	xfer_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.meta = src_toggle;
		state_next.sync = state_reg.meta;
		state_next.last = state_reg.sync;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// meta is read only by sync
	assign dst_pulse = state_reg.sync ^ state_reg.last;

	a_pulse_single: assert property (@(posedge clk) disable iff (rst)
		dst_pulse |=> !dst_pulse) else $error("event pulse longer than one cycle");

endmodule : event_cross

`default_nettype wire

// [verification/prog_model.sv]
`timescale 1ns/1ps
`default_nettype none

module prog_model (
	// test access port, programmer side
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// ************************************************************
	// link clock: 80 ns, held low between frames
	// ************************************************************
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// pins move only while tck is low, so each rise sees settled values
	// uneven halves keep tck rises off the system clock edges
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#37;
		q = tdo;
		tck = 1'b1;
		#43;
		tck = 1'b0;
	endtask : step

	task automatic tap_reset(input int n);
		logic q;
		for (int i = 0; i < n; i++) begin
			step(1'b1, ~tdi, q);
		end
		step(1'b0, ~tdi, q);
	endtask : tap_reset

	// ************************************************************
	// one scan from idle back to idle, with one extra idle clock
	// ************************************************************
	// lsb first
	task automatic scan(input logic ir, input logic [15:0] v, input int n,
		output logic [15:0] r);
		logic q;
		r = '0;
		step(1'b1, ~tdi, q);
		if (ir) begin
			step(1'b1, ~tdi, q);
		end
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], q);
			r[i] = q;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		// released data line must not look like the last bit
		tdi = ~tdi;
	endtask : scan
endmodule : prog_model

`default_nettype wire

// [verification/jtag_flash_programming_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "jtag_prog_cfg.svh"

module jtag_flash_programming_port_bench;
	localparam int TS = 8;
	localparam int TL = 20;
	logic CLK, RST, RST_TMO_SEL, TCK, TMS, TDI, TDO, CHIP_RESET, PROG_MODE;
	logic FLASH_EXEC, PBUF_WE;
	logic [14:0] FLASH_CMD, FLASH_RESULT;
	logic [23:0] FLASH_ADDR, a;
	logic [1:0] PBUF_BE;
	logic [15:0] PBUF_DATA, FLASH_RD_DATA, r, exp_w;
	logic TDO_OE_N;
	logic [7:0] b, lo, hi;
	logic [14:0] exec_q[$];
	logic [17:0] we_q[$];
	logic [14:0] ew[5] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380, 15'h3380};
	int n_errors = 0;
	int checks_done = 0;
	int n, tmo;
	int n_oe = 0;

	jtag_prog_port #(.TMO_SHORT_CYC(TS), .TMO_LONG_CYC(TL)) dut_u (
		.CLK(CLK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
		.TDO_OE_N(TDO_OE_N), .RST_TMO_SEL(RST_TMO_SEL), .CHIP_RESET(CHIP_RESET),
		.PROG_MODE(PROG_MODE), .FLASH_CMD(FLASH_CMD), .FLASH_EXEC(FLASH_EXEC),
		.FLASH_RESULT(FLASH_RESULT), .FLASH_ADDR(FLASH_ADDR), .PBUF_WE(PBUF_WE),
		.PBUF_BE(PBUF_BE), .PBUF_DATA(PBUF_DATA), .FLASH_RD_DATA(FLASH_RD_DATA));

	prog_model p_u (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO));

	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	// ************************************************************
	// flash model and event capture
	// ************************************************************
	function automatic logic [15:0] rd_word(input logic [23:0] w);
		return {w[7:0] ^ 8'h5A, ~w[7:0]};
	endfunction : rd_word

	always @(posedge CLK) begin
		if (FLASH_EXEC === 1'b1) exec_q.push_back(FLASH_CMD);
		if (PBUF_WE === 1'b1) we_q.push_back({PBUF_BE, PBUF_DATA});
		FLASH_RD_DATA <= rd_word(FLASH_ADDR);
	end

	// counts link edges that sample the data line while it is driven
	always @(posedge TCK) begin
		if (TDO_OE_N === 1'b0) n_oe++;
	end

	task automatic wrap_up();
		$display("counts: %0d checks, %0d mismatches", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	function automatic logic ready(input int s);
		case (s)
			0: return exec_q.size() > 0;
			1: return we_q.size() > 0;
			2: return CHIP_RESET === 1'b1;
			default: return PROG_MODE === 1'b1;
		endcase
	endfunction : ready

	task automatic wait_for(input int s, input int lim);
		for (int i = 0; i < lim && !ready(s); i++) @(posedge CLK);
		if (!ready(s)) begin
			n_errors++;
			$display("mismatch wait %0d expected 1 seen 0", s);
			wrap_up();
		end
	endtask : wait_for

	task automatic ir(input logic [3:0] c);
		p_u.scan(1'b1, {12'h000, c}, 4, r);
	endtask : ir

	task automatic do_cmd(input logic [14:0] w);
		logic [14:0] res;
		res = 15'($urandom);
		@(posedge CLK) FLASH_RESULT <= res;
		p_u.scan(1'b0, {1'b0, w}, 15, r);
		chk_val("result", 24'(res), 24'(r[14:0]));
		wait_for(0, 20);
		chk_val("cmd", 24'(w), 24'(exec_q.pop_front()));
	endtask : do_cmd

	task automatic set_addr(input logic [23:0] w);
		do_cmd({`PFX_ADDR_EXT, w[23:16]});
		do_cmd({`PFX_ADDR_HIGH, w[15:8]});
		do_cmd({`PFX_ADDR_LOW, w[7:0]});
		repeat (2) @(posedge CLK);
		chk_val("addr", w, FLASH_ADDR);
	endtask : set_addr

	initial begin
		#3000000;
		n_errors++;
		$display("mismatch watchdog expected finish seen hang");
		wrap_up();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		RST = 1'b1;
		RST_TMO_SEL = 1'b0;
		FLASH_RESULT = '0;
		void'($urandom(67));
		fork
			repeat (8) @(posedge CLK);
			p_u.tap_reset(3);
		join
		@(posedge CLK) RST <= 1'b0;
		p_u.tap_reset(5);
		chk_bit("chip_reset", 1'b0, CHIP_RESET);
		chk_bit("prog_mode", 1'b0, PROG_MODE);
		$display("test reset_values done");

		ir(`IR_CMD);
		p_u.scan(1'b0, 16'h2380, 15, r);
		ir(`IR_FILL);
		p_u.scan(1'b0, 16'h00A5, 8, r);
		repeat (20) @(posedge CLK);
		chk_val("exec_count", 24'h000000, 24'(exec_q.size()));
		chk_val("we_count", 24'h000000, 24'(we_q.size()));
		$display("test locked done");

		for (int s = 0; s < 2; s++) begin
			tmo = s ? TL : TS;
			@(posedge CLK) RST_TMO_SEL <= s[0];
			ir(`IR_RESET);
			p_u.scan(1'b0, 16'h0001, 1, r);
			wait_for(2, 10);
			p_u.scan(1'b0, 16'h0000, 1, r);
			n = 0;
			while (CHIP_RESET === 1'b1 && n < 100) begin
				@(negedge CLK);
				n++;
			end
			// scan tail after the bit drops is about seven cycles, sync two more
			chk_bit("tmo_window", 1'b1, n >= tmo - 5 && n <= tmo - 2);
		end
		p_u.scan(1'b0, 16'h0001, 1, r);
		$display("test chip_reset done");

		ir(`IR_UNLOCK);
		p_u.scan(1'b0, `UNLOCK_KEY ^ (16'h0001 << $urandom_range(15)), 16, r);
		repeat (20) @(posedge CLK);
		chk_bit("bad_key", 1'b0, PROG_MODE);
		n = n_oe;
		p_u.scan(1'b0, `UNLOCK_KEY, 16, r);
		chk_val("oe_count", 24'h000010, 24'(n_oe - n));
		wait_for(3, 20);
		$display("test unlock done");

		ir(`IR_CMD);
		foreach (ew[i]) do_cmd(ew[i]);
		do_cmd(15'h2310);
		a = 24'($urandom);
		set_addr(a);
		lo = 8'($urandom);
		hi = 8'($urandom);
		do_cmd({`PFX_DATA_LOW, lo});
		do_cmd({`PFX_DATA_HIGH, hi});
		do_cmd(15'h3700);
		do_cmd(15'h7700);
		wait_for(1, 20);
		chk_val("latch", 24'({2'b11, hi, lo}), 24'(we_q.pop_front()));
		foreach (ew[i]) do_cmd(i == 2 ? 15'h3500 : 15'h3700);
		$display("test commands done");

		ir(`IR_FILL);
		for (int i = 0; i < 4; i++) begin
			b = 8'($urandom);
			p_u.scan(1'b0, {8'h00, b}, 8, r);
			wait_for(1, 18);
			chk_val("fill", 24'({i[0] ? 2'b10 : 2'b01, b, b}), 24'(we_q.pop_front()));
			repeat (4) @(posedge CLK);
			chk_val("fill_addr", a + 24'(i / 2), FLASH_ADDR);
		end
		$display("test page_fill done");

		ir(`IR_CMD);
		do_cmd(15'h2302);
		a = 24'($urandom);
		set_addr(a);
		do_cmd(15'h3200);
		do_cmd(15'h3600);
		do_cmd(15'h3700);
		ir(`IR_FETCH);
		for (int i = 0; i < 3; i++) begin
			p_u.scan(1'b0, 16'($urandom), 8, r);
			exp_w = rd_word(a + 24'(i / 2));
			chk_val("fetch", 24'(i[0] ? exp_w[15:8] : exp_w[7:0]), 24'(r[7:0]));
		end
		repeat (6) @(posedge CLK);
		chk_val("fetch_addr", a + 24'h000001, FLASH_ADDR);
		ir(`IR_UNLOCK);
		p_u.scan(1'b0, 16'h0000, 16, r);
		repeat (20) @(posedge CLK);
		chk_bit("exit_prog", 1'b0, PROG_MODE);
		$display("test page_fetch done");
		wrap_up();
	end
endmodule : jtag_flash_programming_port_bench

`default_nettype wire
